// ===== core/bwoc_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
// Function
// - Registers decode at fixed offsets 00h to 20h from the block base.
// - Clock alarm status bit 17 sets on alarm when latch enabled; battery reset clears.
// - Bit 17 clears only by writing its latch clear bit.
// - Week alarm status bit 16 sets on alarm when latch enabled; battery reset clears.
// - Bit 16 clears only by writing its latch clear bit.
// - Bit 12 bypasses all wake input glitch filters; defaults zero.
// - With main supply up and bit 11 set, output follows firmware level.
// - With bit 11 clear, hardware logic drives the output.
// - Bit 10 sets or clears the output under firmware control; resets zero.
// - Bit 9 reports the present output pin level.
// - Bits 6:0 show latched assertion if latching enabled, else present state.
// - Wake state bits are taken after polarity inversion.
// - After reset wake state bits 0-3 and 6 follow the pins; bits 4 and 5 show their latches.
// - Hardware asserts output on any enabled wake input or either alarm.
// - Without main power good hardware controls the output regardless of select.
// - An asserted wake input blocks clearing its latch.
module bwoc_top (
   input wire logic clock,
   input wire logic reset,
   input wire logic system_domain_reset,
   input wire logic [7:0] address,
   input wire logic [31:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [31:0] read_data,
   input wire logic [6:0] wake_input,
   input wire logic clock_alarm,
   input wire logic week_alarm,
   input wire logic main_power_good,
   output logic power_request_out
);
   localparam int N = bwoc_pkg::WAKE_COUNT;

   logic filter_bypass_reg;
   logic firmware_output_select_reg;
   logic firmware_output_level_reg;
   logic [N-1:0] latch_en_reg;
   logic clock_alarm_latch_en_reg;
   logic week_alarm_latch_en_reg;
   logic [N-1:0] input_en_reg;
   logic [N-1:0] wake_input_invert_reg;
   logic [N-1:0] buf_en_reg;
   logic [N-1:0] filtered;
   logic [N-1:0] filtered_prev_reg;
   logic [N-1:0] asserted;
   logic [N-1:0] wake_latched;
   logic [N-1:0] wake_effective;
   logic [N-1:0] wake_state_bits;
   logic [N-1:0] edge_active;
   logic [N-1:0] rise_status;
   logic [N-1:0] fall_status;
   logic [N-1:0] rise_clear;
   logic [N-1:0] fall_clear;
   logic [N-1:0] wake_clear;
   logic [1:0] alarm_clear;
   logic [1:0] alarm_status;
   logic [1:0] alarm_in;
   logic [1:0] alarm_le;
   logic clock_alarm_status;
   logic week_alarm_status;
   logic clock_alarm_effective;
   logic week_alarm_effective;
   logic power_good_sync;
   logic hardware_request;
   logic firmware_active;
   logic power_request_next;
   logic wr_ctrl;
   logic wr_latch_en;
   logic wr_latch_clr;
   logic wr_input_en;
   logic wr_polarity;
   logic wr_rise;
   logic wr_fall;
   logic wr_buf_en;
   logic [31:0] ctrl_word;
   logic [31:0] read_next;

   // Address decode of the write strobe
   assign wr_ctrl = write_strobe && address == bwoc_pkg::OFF_CTRL_STATUS;
   assign wr_latch_en = write_strobe && address == bwoc_pkg::OFF_LATCH_EN;
   assign wr_latch_clr = write_strobe && address == bwoc_pkg::OFF_LATCH_CLR;
   assign wr_input_en = write_strobe && address == bwoc_pkg::OFF_INPUT_EN;
   assign wr_polarity = write_strobe && address == bwoc_pkg::OFF_POLARITY;
   assign wr_rise = write_strobe && address == bwoc_pkg::OFF_RISE;
   assign wr_fall = write_strobe && address == bwoc_pkg::OFF_FALL;
   assign wr_buf_en = write_strobe && address == bwoc_pkg::OFF_BUF_EN;

   // Filter bypass lives only in the battery domain
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         filter_bypass_reg <= 1'b0;
      end else if (wr_ctrl) begin
         filter_bypass_reg <= write_data[bwoc_pkg::BIT_FILTER_BYPASS];
      end
   end

   // Firmware select and level also drop on system reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         firmware_output_select_reg <= 1'b0;
         firmware_output_level_reg <= 1'b0;
      end else if (system_domain_reset) begin
         firmware_output_select_reg <= 1'b0;
         firmware_output_level_reg <= 1'b0;
      end else if (wr_ctrl) begin
         firmware_output_select_reg <= write_data[bwoc_pkg::BIT_FW_SELECT];
         firmware_output_level_reg <= write_data[bwoc_pkg::BIT_FW_LEVEL];
      end
   end

   // Latch enables for wake inputs and both alarms
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         latch_en_reg <= bwoc_pkg::LATCH_EN_RESET;
         clock_alarm_latch_en_reg <= bwoc_pkg::ALARM_LE_RESET[1];
         week_alarm_latch_en_reg <= bwoc_pkg::ALARM_LE_RESET[0];
      end else if (wr_latch_en) begin
         latch_en_reg <= write_data[N-1:0];
         clock_alarm_latch_en_reg <= write_data[bwoc_pkg::BIT_CLOCK_ALARM];
         week_alarm_latch_en_reg <= write_data[bwoc_pkg::BIT_WEEK_ALARM];
      end
   end

   // Input routing configuration
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         input_en_reg <= bwoc_pkg::INPUT_EN_RESET;
         wake_input_invert_reg <= bwoc_pkg::POLARITY_RESET;
         buf_en_reg <= bwoc_pkg::BUF_EN_RESET;
      end else begin
         if (wr_input_en) begin
            input_en_reg <= write_data[N-1:0];
         end
         if (wr_polarity) begin
            wake_input_invert_reg <= write_data[N-1:0];
         end
         if (wr_buf_en) begin
            buf_en_reg <= write_data[N-1:0];
         end
      end
   end

   // Per pin synchroniser and glitch filter
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_wake
         bwoc_input_filter #(
            .IDLE_LEVEL(bwoc_pkg::PIN_IDLE_LEVEL)
         ) u_filter (
            .clock(clock),
            .reset(reset),
            .pin_in(wake_input[gi]),
            .bypass(filter_bypass_reg),
            .level_out(filtered[gi])
         );
      end
   endgenerate

   // Power good is a plain level, so only its synchroniser is used
   bwoc_input_filter #(
      .IDLE_LEVEL(1'b0)
   ) u_power_good (
      .clock(clock),
      .reset(reset),
      .pin_in(main_power_good),
      .bypass(1'b1),
      .level_out(power_good_sync)
   );

   // Pins idle high; inversion turns a pin into active high
   assign asserted = ~(filtered ^ wake_input_invert_reg);

   // Edge detection ahead of polarity, on inputs with buffer enable or input enable set
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         filtered_prev_reg <= {N{bwoc_pkg::PIN_IDLE_LEVEL}};
      end else begin
         filtered_prev_reg <= filtered;
      end
   end

   assign edge_active = buf_en_reg | input_en_reg;
   assign rise_clear = wr_rise ? write_data[N-1:0] : '0;
   assign fall_clear = wr_fall ? write_data[N-1:0] : '0;

   bwoc_event_latch #(
      .WIDTH(N)
   ) u_rise (
      .clock(clock),
      .reset(reset),
      .set_in(filtered & ~filtered_prev_reg),
      .set_enable(edge_active),
      .clear_in(rise_clear),
      .state_out(rise_status)
   );

   bwoc_event_latch #(
      .WIDTH(N)
   ) u_fall (
      .clock(clock),
      .reset(reset),
      .set_in(~filtered & filtered_prev_reg),
      .set_enable(edge_active),
      .clear_in(fall_clear),
      .state_out(fall_status)
   );

   // Wake latches: an asserted input overrides the clear request
   assign wake_clear = wr_latch_clr ? write_data[N-1:0] : '0;

   bwoc_event_latch #(
      .WIDTH(N)
   ) u_wake_latch (
      .clock(clock),
      .reset(reset),
      .set_in(asserted),
      .set_enable(latch_en_reg),
      .clear_in(wake_clear),
      .state_out(wake_latched)
   );

   assign wake_effective = (latch_en_reg & wake_latched) | (~latch_en_reg & asserted);
   // Reported as pin sense: 1 means not asserted, from live pins after reset except latched bits 4 and 5
   assign wake_state_bits = ~wake_effective;

   // Alarm latches share the same set-over-clear behaviour
   assign alarm_in = {clock_alarm, week_alarm};
   assign alarm_le = {clock_alarm_latch_en_reg, week_alarm_latch_en_reg};
   assign alarm_clear[1] = wr_latch_clr && write_data[bwoc_pkg::BIT_CLOCK_ALARM];
   assign alarm_clear[0] = wr_latch_clr && write_data[bwoc_pkg::BIT_WEEK_ALARM];

   bwoc_event_latch #(
      .WIDTH(2)
   ) u_alarm_latch (
      .clock(clock),
      .reset(reset),
      .set_in(alarm_in),
      .set_enable(alarm_le),
      .clear_in(alarm_clear),
      .state_out(alarm_status)
   );

   assign clock_alarm_status = alarm_status[1];
   assign week_alarm_status = alarm_status[0];
   assign clock_alarm_effective = clock_alarm_latch_en_reg ? clock_alarm_status : clock_alarm;
   assign week_alarm_effective = week_alarm_latch_en_reg ? week_alarm_status : week_alarm;

   // Hardware request term and source selection
   assign hardware_request = |(input_en_reg & wake_effective) | clock_alarm_effective
                             | week_alarm_effective;
   assign firmware_active = power_good_sync && firmware_output_select_reg;
   // Level set before select keeps this mux from glitching, software's duty
   assign power_request_next = firmware_active ? firmware_output_level_reg
                                               : hardware_request;

   // Registered output; bit 9 reads this same flop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         power_request_out <= 1'b0;
      end else begin
         power_request_out <= power_request_next;
      end
   end

   // Control/status word; unlisted bits stay zero
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[bwoc_pkg::BIT_CLOCK_ALARM] = clock_alarm_status;
      ctrl_word[bwoc_pkg::BIT_WEEK_ALARM] = week_alarm_status;
      ctrl_word[bwoc_pkg::BIT_FILTER_BYPASS] = filter_bypass_reg;
      ctrl_word[bwoc_pkg::BIT_FW_SELECT] = firmware_output_select_reg;
      ctrl_word[bwoc_pkg::BIT_FW_LEVEL] = firmware_output_level_reg;
      ctrl_word[bwoc_pkg::BIT_OUT_STATUS] = power_request_out;
      ctrl_word[N-1:0] = wake_state_bits;
   end

   // Read mux; latch clear, reserved and unmapped addresses read zero
   always_comb begin
      read_next = 32'h0000_0000;
      unique case (address)
         bwoc_pkg::OFF_CTRL_STATUS: read_next = ctrl_word;
         bwoc_pkg::OFF_LATCH_EN: begin
            read_next[N-1:0] = latch_en_reg;
            read_next[bwoc_pkg::BIT_CLOCK_ALARM] = clock_alarm_latch_en_reg;
            read_next[bwoc_pkg::BIT_WEEK_ALARM] = week_alarm_latch_en_reg;
         end
         bwoc_pkg::OFF_INPUT_EN: read_next[N-1:0] = input_en_reg;
         bwoc_pkg::OFF_POLARITY: read_next[N-1:0] = wake_input_invert_reg;
         bwoc_pkg::OFF_RISE: read_next[N-1:0] = rise_status;
         bwoc_pkg::OFF_FALL: read_next[N-1:0] = fall_status;
         bwoc_pkg::OFF_BUF_EN: read_next[N-1:0] = buf_en_reg;
         default: read_next = 32'h0000_0000;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         read_data <= 32'h0000_0000;
      end else if (read_strobe) begin
         read_data <= read_next;
      end else begin
         read_data <= 32'h0000_0000;
      end
   end
endmodule : bwoc_top

// ===== core/bwoc_pkg.sv
package bwoc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
   localparam logic [7:0] OFF_LATCH_EN = 8'h04;
   localparam logic [7:0] OFF_LATCH_CLR = 8'h08;
   localparam logic [7:0] OFF_INPUT_EN = 8'h0C;
   localparam logic [7:0] OFF_RESERVED = 8'h10;
   localparam logic [7:0] OFF_POLARITY = 8'h14;
   localparam logic [7:0] OFF_RISE = 8'h18;
   localparam logic [7:0] OFF_FALL = 8'h1C;
   localparam logic [7:0] OFF_BUF_EN = 8'h20;

   // Field positions
   localparam int WAKE_COUNT = 7;
   localparam int BIT_CLOCK_ALARM = 17;
   localparam int BIT_WEEK_ALARM = 16;
   localparam int BIT_FILTER_BYPASS = 12;
   localparam int BIT_FW_SELECT = 11;
   localparam int BIT_FW_LEVEL = 10;
   localparam int BIT_OUT_STATUS = 9;

   // Reset values
   localparam logic [6:0] LATCH_EN_RESET = 7'h30;
   localparam logic [1:0] ALARM_LE_RESET = 2'h0;
   localparam logic [6:0] INPUT_EN_RESET = 7'h7F;
   localparam logic [6:0] POLARITY_RESET = 7'h00;
   localparam logic [6:0] BUF_EN_RESET = 7'h7F;
   localparam logic PIN_IDLE_LEVEL = 1'b1;

   // Glitch filter timing
   localparam int CLOCK_MHZ = 200;
   localparam int FILTER_NS = 100;
   localparam int FILTER_CYCLES = (FILTER_NS * CLOCK_MHZ + 999) / 1000;
   localparam int FILTER_W = 8;
endpackage : bwoc_pkg

// ===== core/bwoc_input_filter.sv
`timescale 1ns/100ps
module bwoc_input_filter #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic pin_in,
   input wire logic bypass,
   output logic level_out
);
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;
   logic [bwoc_pkg::FILTER_W-1:0] count_reg;
   logic agree;

   // Three stage synchroniser; only the second stage reads the first
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync1_reg <= IDLE_LEVEL;
         sync2_reg <= IDLE_LEVEL;
         sync3_reg <= IDLE_LEVEL;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign agree = (sync2_reg == sync3_reg);

   // A new level must hold for the filter time unless bypassed
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count_reg <= '0;
         level_out <= IDLE_LEVEL;
      end else if (!agree || sync3_reg == level_out) begin
         count_reg <= '0;
      end else if (bypass || count_reg == bwoc_pkg::FILTER_W'(bwoc_pkg::FILTER_CYCLES - 1)) begin
         count_reg <= '0;
         level_out <= sync3_reg;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule : bwoc_input_filter

// ===== core/bwoc_event_latch.sv
`timescale 1ns/100ps
module bwoc_event_latch #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] set_enable,
   input wire logic [WIDTH-1:0] clear_in,
   output logic [WIDTH-1:0] state_out
);
   logic [WIDTH-1:0] state_next;

   // A set in the clearing cycle wins so no event is lost
   assign state_next = (state_out & ~clear_in) | (set_in & set_enable);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_out <= '0;
      end else begin
         state_out <= state_next;
      end
   end
endmodule : bwoc_event_latch

// ===== sim/bwoc_assertions.sv
`timescale 1ns/100ps
module bwoc_assertions (
   input wire logic clock,
   input wire logic reset,
   input wire logic system_domain_reset,
   input wire logic [7:0] address,
   input wire logic [31:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [31:0] read_data,
   input wire logic [6:0] wake_input,
   input wire logic clock_alarm,
   input wire logic week_alarm,
   input wire logic main_power_good,
   input wire logic power_request_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Read bus is quiet outside the answer cycle
   read_idle_a: assert property (
      !$past(read_strobe) |-> read_data == 32'h0) else $error("read data outside answer cycle");
   unmapped_zero_a: assert property (
      $past(read_strobe) && ($past(address) inside {8'h08, 8'h10} || $past(address) > 8'h20) |-> read_data == 32'h0)
      else $error("unmapped read not zero");
   reserved_zero_a: assert property (
      $past(read_strobe) && $past(address) == 8'h00 |-> {read_data[31:18], read_data[15:13], read_data[8:7]} == 19'h0)
      else $error("reserved control bits not zero");
   // Status bit is captured from the output flop at the strobe edge
   out_status_a: assert property (
      $past(read_strobe) && $past(address) == 8'h00 |-> read_data[9] == $past(power_request_out))
      else $error("output status bit wrong");
   // Without main supply either alarm must raise the request within the sync latency
   hw_source_a: assert property (
      (!main_power_good && (clock_alarm || week_alarm))[*6] |=> power_request_out) else $error("alarm not on output");
   fw_on_a: assert property (
      main_power_good[*4] ##0 (write_strobe && address == 8'h00 && write_data[11:10] == 2'h3 && !system_domain_reset)
      |-> ##[1:3] power_request_out) else $error("firmware high not driven");
   fw_off_a: assert property (
      main_power_good[*4] ##0 (write_strobe && address == 8'h00 && write_data[11:10] == 2'h2 && !system_domain_reset)
      |-> ##[1:3] !power_request_out) else $error("firmware low not driven");
   sys_reset_a: assert property (
      $past(system_domain_reset, 2) && $past(system_domain_reset) && $past(read_strobe) && $past(address) == 8'h00
      |-> read_data[11:10] == 2'h0) else $error("system reset left firmware bits");
   reset_quiet_a: assert property (disable iff (1'h0)
      reset |-> !power_request_out && read_data == 32'h0) else $error("outputs active in reset");
endmodule : bwoc_assertions

bind bwoc_top bwoc_assertions chk (.clock(clock), .reset(reset), .system_domain_reset(system_domain_reset),
   .address(address), .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
   .read_data(read_data), .wake_input(wake_input), .clock_alarm(clock_alarm), .week_alarm(week_alarm),
   .main_power_good(main_power_good), .power_request_out(power_request_out));

// ===== sim/bwoc_partner.sv
`timescale 1ns/100ps
module bwoc_partner #(
   parameter int PG_DELAY = 40
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [6:0] press,
   input wire logic [1:0] alarm_req,
   input wire logic power_request_out,
   output logic [6:0] wake_input,
   output logic clock_alarm,
   output logic week_alarm,
   output logic main_power_good
);
   int count;
   // Buttons pull their pin low; a released pin rests at the pull-up level
   assign wake_input = ~press;
   // Alarm timers change on the block clock
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         clock_alarm <= 1'h0;
         week_alarm <= 1'h0;
      end else begin
         clock_alarm <= alarm_req[0];
         week_alarm <= alarm_req[1];
      end
   end
   // Regulator ramp: supply good lags the request in both directions
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         count <= 0;
         main_power_good <= 1'h0;
      end else if (power_request_out == main_power_good) begin
         count <= 0;
      end else if (count == PG_DELAY) begin
         main_power_good <= power_request_out;
         count <= 0;
      end else begin
         count <= count + 1;
      end
   end
endmodule : bwoc_partner

// ===== sim/test_battery_wake_output_control.sv
`timescale 1ns/100ps
module test_battery_wake_output_control;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic [31:0] mask;
      logic [31:0] exp;
   } bwoc_row_t;
   logic clock = 1'h0;
   logic reset = 1'h0;
   logic system_domain_reset = 1'h0;
   logic [7:0] address = 8'h00;
   logic [31:0] write_data = 32'h0;
   logic write_strobe = 1'h0;
   logic read_strobe = 1'h0;
   logic [6:0] press = 7'h00;
   logic [1:0] alarm_req = 2'h0;
   logic [31:0] read_data, got;
   logic [6:0] wake_input;
   logic clock_alarm, week_alarm, main_power_good, power_request_out;
   int fails = 0;
   int comparisons = 0;
   bwoc_row_t rows [11] = '{
      '{8'h00, 32'hFFFF_F7FF, 32'hFFFF_F5FF, 32'h0000_147F}, '{8'h00, 32'h0, 32'hFFFF_F5FF, 32'h0000_007F},
      '{8'h04, 32'hFFFF_FFFF, 32'h0003_007F, 32'h0003_007F}, '{8'h04, 32'h0003_0030, 32'h0003_007F, 32'h0003_0030},
      '{8'h0C, 32'h0000_0005, 32'h0000_007F, 32'h0000_0005}, '{8'h0C, 32'h0000_007F, 32'h0000_007F, 32'h0000_007F},
      '{8'h14, 32'h0, 32'h0000_007F, 32'h0}, '{8'h18, 32'hFFFF_FFFF, 32'h0000_007F, 32'h0},
      '{8'h20, 32'h0000_007F, 32'h0000_007F, 32'h0000_007F}, '{8'h10, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
      '{8'h40, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0}};

   bwoc_top dut (.clock(clock), .reset(reset), .system_domain_reset(system_domain_reset), .address(address),
      .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
      .wake_input(wake_input), .clock_alarm(clock_alarm), .week_alarm(week_alarm),
      .main_power_good(main_power_good), .power_request_out(power_request_out));
   bwoc_partner far_side (.clock(clock), .reset(reset), .press(press), .alarm_req(alarm_req),
      .power_request_out(power_request_out), .wake_input(wake_input), .clock_alarm(clock_alarm),
      .week_alarm(week_alarm), .main_power_good(main_power_good));

   // Free running 200 MHz clock
   always #2.5 clock = ~clock;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      write_strobe <= 1'h1;
      address <= a;
      write_data <= d;
      @(posedge clock);
      write_strobe <= 1'h0;
   endtask : reg_write

   // Data are taken just after the edge that closes the strobe cycle
   task automatic reg_read(input logic [7:0] a);
      @(posedge clock);
      read_strobe <= 1'h1;
      address <= a;
      @(posedge clock);
      read_strobe <= 1'h0;
      #1 got = read_data;
   endtask : reg_read

   // Bounded wait: the pin path has sync and filter latency
   task automatic wait_out(input logic v, input int limit);
      int n = 0;
      while (power_request_out !== v && n < limit) begin
         @(posedge clock);
         n++;
      end
      check("power_request_out", {31'h0, v}, {31'h0, power_request_out});
   endtask : wait_out

   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Watchdog sized well above the whole sequence
   initial begin
      #100000;
      fails++;
      wrap_up();
   end

   initial begin
      // Raised by a non-blocking write so the async reset sees a real edge before the first clock
      reset <= 1'h1;
      repeat (5) @(posedge clock);
      reset <= 1'h0;
      reg_read(8'h00);
      check("control after reset", 32'h0000_007F, got);
      reg_read(8'h04);
      check("latch enable after reset", 32'h0000_0030, got & 32'h0003_007F);
      $display("reset test done");
      foreach (rows[i]) begin
         reg_write(rows[i].addr, rows[i].wdata);
         reg_read(rows[i].addr);
         check("register row", rows[i].exp, got & rows[i].mask);
      end
      $display("register table test done");
      press <= 7'h01;
      wait_out(1'h1, 60);
      reg_read(8'h00);
      check("pressed status", 32'h0000_027E, got);
      reg_write(8'h00, 32'h0000_0400);
      reg_write(8'h00, 32'h0000_0C00);
      repeat (60) @(posedge clock);
      press <= 7'h00;
      repeat (40) @(posedge clock);
      wait_out(1'h1, 0);
      reg_write(8'h00, 32'h0000_0C00);
      reg_write(8'h00, 32'h0000_0800);
      wait_out(1'h0, 10);
      press <= 7'h40;
      wait_out(1'h1, 120);
      reg_write(8'h00, 32'h0);
      press <= 7'h00;
      wait_out(1'h0, 60);
      $display("output control test done");
      for (int k = 0; k < 2; k++) begin
         // Held long enough that the hardware source assertion sees it
         alarm_req <= 2'(1 << k);
         repeat (8) @(posedge clock);
         alarm_req <= 2'h0;
         repeat (5) @(posedge clock);
         wait_out(1'h1, 0);
         reg_read(8'h00);
         check("alarm status", 32'h0002_0000 >> k, got & 32'h0003_0000);
         reg_write(8'h08, 32'h0002_0000 >> k);
         reg_read(8'h00);
         check("alarm cleared", 32'h0, got & 32'h0003_0000);
         wait_out(1'h0, 60);
      end
      $display("alarm test done");
      press <= 7'h10;
      repeat (30) @(posedge clock);
      reg_write(8'h08, 32'h0000_0010);
      reg_read(8'h00);
      check("latch held while pressed", 32'h0, got & 32'h0000_0010);
      press <= 7'h00;
      repeat (30) @(posedge clock);
      reg_read(8'h00);
      check("latch held after release", 32'h0, got & 32'h0000_0010);
      // Pins 0, 4 and 6 have each been pressed and released by now
      reg_read(8'h1C);
      check("falling edge status", 32'h0000_0051, got & 32'h0000_007F);
      reg_read(8'h18);
      check("rising edge status", 32'h0000_0051, got & 32'h0000_007F);
      reg_write(8'h08, 32'h0000_0010);
      reg_read(8'h00);
      check("latch cleared", 32'h0000_0010, got & 32'h0000_0010);
      wait_out(1'h0, 60);
      reg_write(8'h14, 32'h0000_0002);
      repeat (5) @(posedge clock);
      reg_read(8'h00);
      check("inverted input state", 32'h0000_007D, got & 32'h0000_007F);
      reg_write(8'h14, 32'h0);
      wait_out(1'h0, 60);
      $display("latch and polarity test done");
      // Battery reset in mid-run must drop a latched alarm and restore defaults
      reg_write(8'h04, 32'h0002_0030);
      alarm_req <= 2'h1;
      repeat (3) @(posedge clock);
      alarm_req <= 2'h0;
      reg_read(8'h00);
      check("alarm before battery reset", 32'h0002_0000, got & 32'h0003_0000);
      @(posedge clock);
      reset <= 1'h1;
      repeat (2) @(posedge clock);
      reset <= 1'h0;
      reg_read(8'h00);
      check("control after battery reset", 32'h0000_007F, got);
      $display("battery reset test done");
      reg_write(8'h00, 32'h0000_1400);
      reg_write(8'h00, 32'h0000_1C00);
      system_domain_reset <= 1'h1;
      repeat (2) @(posedge clock);
      reg_read(8'h00);
      system_domain_reset <= 1'h0;
      check("system reset fields", 32'h0000_1000, got & 32'h0000_1C00);
      $display("system reset test done");
      wrap_up();
   end
endmodule : test_battery_wake_output_control
